// ---- hdl/hsp_top.sv ----
// dual channel host slave port with fast gate and host request latches
// assumes an ahb-lite master on hclk and host pins sampled on hclk
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "hsp_map.svh"

module hsp_top
  import hsp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire hsp_host_in_t host_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic addr_gate_pin,
  output logic addr_gate_oe,
  output logic host_req_a,
  output logic host_req_b,
  output logic host_req_c,
  output logic chan_a_input_irq,
  output logic chan_b_input_irq
);

  // address decode, shared by reads and writes
  function automatic hsp_sel_t reg_decode(input logic [15:0] a,
                                          input logic en);
    hsp_sel_t s;
    case (a)
      `HSP_OFF_SYSCTL: s = SEL_SYS;
      `HSP_OFF_HPCTL: s = SEL_HPC;
      `HSP_OFF_A_IN: s = SEL_A_IN;
      `HSP_OFF_A_OUT: s = SEL_A_OUT;
      `HSP_OFF_A_STAT: s = SEL_A_STAT;
      `HSP_OFF_B_IN: s = SEL_B_IN;
      `HSP_OFF_B_OUT: s = SEL_B_OUT;
      `HSP_OFF_B_STAT: s = SEL_B_STAT;
      `HSP_OFF_PORT: s = SEL_PORT;
      `HSP_OFF_DIR: s = SEL_DIR;
      default: s = SEL_NONE;
    endcase
    if (a[15:4] == `HSP_GUARD_HI && !en)
      s = SEL_NONE; // top window hidden while disabled
    return s;
  endfunction

  // status byte: user bits, command flag, input and output full
  function automatic logic [7:0] stat_byte(input logic [7:0] u,
    input logic cd, input logic input_full_flag, input logic output_full_flag);
    return {u[7:4], cd, u[2], input_full_flag, output_full_flag};
  endfunction

  hsp_host_in_t s1_reg, s2_reg, s3_reg;
  logic [7:0] sysctl_reg, port_reg, dir_reg;
  logic [2:0] hpc_reg, hreq_reg, rz_reg;
  logic [7:0] idr_a_reg, idr_b_reg, odr_a_reg, odr_b_reg;
  logic [7:0] usr_a_reg, usr_b_reg;
  logic cd_a_reg, cd_b_reg, ibf_a_reg, ibf_b_reg, obf_a_reg, obf_b_reg;
  hsp_gate_state_t gate_reg, gate_next;
  logic wr_pend_reg;
  hsp_sel_t wr_sel_reg, sel_f;
  logic [7:0] rd_byte, wbyte;
  logic h_en, fast, accept, rd_hit, wr_fire;
  logic sel_a2, sel_b2, sel_a3, sel_b3;
  logic wr_rise, a_wr, b_wr, rd_fall, rd_rise;
  logic a_clr_req, b_clr_req, a_obf_clr, b_obf_clr;
  logic suppress, set_gate;

  // three stage capture of the host pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_reg <= hsp_host_in_t'(`HSP_HOST_IDLE);
      s2_reg <= hsp_host_in_t'(`HSP_HOST_IDLE);
      s3_reg <= hsp_host_in_t'(`HSP_HOST_IDLE);
    end
    else
    begin
      s1_reg <= host_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // host strobe edges, only with exactly one channel selected
  assign h_en = sysctl_reg[`HSP_HIE_BIT];
  assign fast = hpc_reg[`HSP_FGE_BIT];
  assign sel_a2 = !s2_reg.a_sel_n && s2_reg.b_sel_n;
  assign sel_b2 = !s2_reg.b_sel_n && s2_reg.a_sel_n;
  assign sel_a3 = !s3_reg.a_sel_n && s3_reg.b_sel_n;
  assign sel_b3 = !s3_reg.b_sel_n && s3_reg.a_sel_n;
  assign wr_rise = h_en && s2_reg.wr_n && !s3_reg.wr_n && s3_reg.rd_n;
  assign a_wr = wr_rise && sel_a3;
  assign b_wr = wr_rise && sel_b3;
  assign rd_fall = h_en && !s2_reg.rd_n && s3_reg.rd_n && s2_reg.wr_n;
  assign rd_rise = h_en && s2_reg.rd_n && !s3_reg.rd_n && s3_reg.wr_n;
  assign a_clr_req = rd_fall && sel_a2 && !s2_reg.addr;
  assign b_clr_req = rd_fall && sel_b2 && !s2_reg.addr;
  assign a_obf_clr = rd_rise && sel_a3 && !s3_reg.addr;
  assign b_obf_clr = rd_rise && sel_b3 && !s3_reg.addr;

  // bus side: writes take one wait state, reads none
  assign accept = hsel && htrans[1] && hready &&
                  hsize == `HSP_HSIZE_WORD;
  assign sel_f = reg_decode(haddr[15:0], h_en);
  assign rd_hit = accept && !hwrite;
  assign wr_fire = wr_pend_reg;
  assign wbyte = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_sel_reg <= SEL_NONE;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      if (accept && hwrite)
      begin
        wr_pend_reg <= 1'b1;
        wr_sel_reg <= sel_f;
        hreadyout <= 1'b0;
      end
      else
      begin
        wr_pend_reg <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  // read data mux
  always_comb
  begin
    case (sel_f)
      SEL_SYS: rd_byte = sysctl_reg;
      SEL_HPC: rd_byte = {`HSP_HPCTL_FILL, hpc_reg};
      SEL_A_IN: rd_byte = idr_a_reg;
      SEL_A_OUT: rd_byte = odr_a_reg;
      SEL_A_STAT: rd_byte = stat_byte(usr_a_reg, cd_a_reg, ibf_a_reg,
                                      obf_a_reg);
      SEL_B_IN: rd_byte = idr_b_reg;
      SEL_B_OUT: rd_byte = odr_b_reg;
      SEL_B_STAT: rd_byte = stat_byte(usr_b_reg, cd_b_reg, ibf_b_reg,
                                      obf_b_reg);
      SEL_PORT: rd_byte = {port_reg[7:6], hreq_reg, port_reg[2:0]};
      SEL_DIR: rd_byte = dir_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd_hit)
      hrdata <= {24'h000000, rd_byte};
  end

  // system and host port control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sysctl_reg <= `HSP_SYSCTL_RST;
      hpc_reg <= 3'h0;
    end
    else if (wr_fire)
    begin
      if (wr_sel_reg == SEL_SYS)
        sysctl_reg <= (wbyte & ~`HSP_SYSCTL_RO) |
                      (sysctl_reg & `HSP_SYSCTL_RO);
      if (wr_sel_reg == SEL_HPC)
        hpc_reg <= wbyte[2:0];
    end
  end

  // fast gate command decoder, channel a writes only
  always_comb
  begin
    gate_next = gate_reg;
    suppress = 1'b0;
    set_gate = 1'b0;
    if (!fast)
      gate_next = GS_IDLE;
    else if (a_wr)
    begin
      case (gate_reg)
        GS_IDLE:
        begin
          if (s3_reg.addr && s3_reg.data == `HSP_CMD_GATE)
          begin
            suppress = 1'b1;
            gate_next = GS_WAIT;
          end
        end
        GS_WAIT:
        begin
          if (!s3_reg.addr)
          begin
            set_gate = 1'b1;
            suppress = 1'b1;
            gate_next = GS_DONE;
          end
          else if (s3_reg.data == `HSP_CMD_GATE)
            suppress = 1'b1;
          else
            gate_next = GS_IDLE;
        end
        GS_DONE:
        begin
          if (s3_reg.addr && s3_reg.data == `HSP_CMD_END)
          begin
            suppress = 1'b1;
            gate_next = GS_IDLE;
          end
          else if (s3_reg.addr && s3_reg.data == `HSP_CMD_GATE)
          begin
            suppress = 1'b1;
            gate_next = GS_WAIT;
          end
          else
            gate_next = GS_IDLE;
        end
        default: gate_next = GS_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gate_reg <= GS_IDLE;
    else
      gate_reg <= gate_next;
  end

  // channel a input register, command flag and input full
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idr_a_reg <= 8'h00;
      cd_a_reg <= 1'b0;
      ibf_a_reg <= 1'b0;
    end
    else
    begin
      if (a_wr)
      begin
        idr_a_reg <= s3_reg.data;
        cd_a_reg <= s3_reg.addr;
      end
      if (a_wr && !suppress)
        ibf_a_reg <= 1'b1;
      else if (rd_hit && sel_f == SEL_A_IN)
        ibf_a_reg <= 1'b0;
    end
  end

  // channel b input register, command flag and input full
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idr_b_reg <= 8'h00;
      cd_b_reg <= 1'b0;
      ibf_b_reg <= 1'b0;
    end
    else
    begin
      if (b_wr)
      begin
        idr_b_reg <= s3_reg.data;
        cd_b_reg <= s3_reg.addr;
      end
      if (b_wr)
        ibf_b_reg <= 1'b1;
      else if (rd_hit && sel_f == SEL_B_IN)
        ibf_b_reg <= 1'b0;
    end
  end

  // output registers, output full flags and user status bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      odr_a_reg <= 8'h00;
      odr_b_reg <= 8'h00;
      obf_a_reg <= 1'b0;
      obf_b_reg <= 1'b0;
      usr_a_reg <= 8'h00;
      usr_b_reg <= 8'h00;
    end
    else
    begin
      if (wr_fire && wr_sel_reg == SEL_A_OUT)
      begin
        odr_a_reg <= wbyte;
        obf_a_reg <= 1'b1;
      end
      else if (a_obf_clr)
        obf_a_reg <= 1'b0;
      if (wr_fire && wr_sel_reg == SEL_B_OUT)
      begin
        odr_b_reg <= wbyte;
        obf_b_reg <= 1'b1;
      end
      else if (b_obf_clr)
        obf_b_reg <= 1'b0;
      if (wr_fire && wr_sel_reg == SEL_A_STAT)
        usr_a_reg <= wbyte & `HSP_STAT_USER;
      if (wr_fire && wr_sel_reg == SEL_B_STAT)
        usr_b_reg <= wbyte & `HSP_STAT_USER;
    end
  end

  // port data and direction; bit 7 is the gate level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_reg <= `HSP_PORT_RST;
      dir_reg <= 8'h00;
    end
    else
    begin
      if (wr_fire && wr_sel_reg == SEL_DIR)
        dir_reg <= wbyte;
      if (wr_fire && wr_sel_reg == SEL_PORT)
      begin
        port_reg[2:0] <= wbyte[2:0];
        port_reg[6] <= wbyte[6];
        if (!fast)
          port_reg[`HSP_GATE_BIT] <= wbyte[`HSP_GATE_BIT];
      end
      if (set_gate)
        port_reg[`HSP_GATE_BIT] <= s3_reg.data[1];
    end
  end

  // host request latches on port bits 3, 4 and 5
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreq_reg <= 3'h0;
      rz_reg <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wr_fire && wr_sel_reg == SEL_PORT)
        begin
          hreq_reg[i] <= wbyte[i + 3] & (hreq_reg[i] | rz_reg[i]);
          rz_reg[i] <= 1'b0;
        end
        else
        begin
          if ((i == 0 && b_clr_req) || (i != 0 && a_clr_req))
            hreq_reg[i] <= 1'b0;
          if (rd_hit && sel_f == SEL_PORT && !hreq_reg[i])
            rz_reg[i] <= 1'b1;
        end
      end
    end
  end

  // host data bus: output or status by address bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      host_data_out <= 8'h00;
      host_data_oe <= 1'b0;
    end
    else
    begin
      host_data_oe <= h_en && !s2_reg.rd_n && s2_reg.wr_n &&
                      (sel_a2 || sel_b2);
      if (sel_a2)
        host_data_out <= s2_reg.addr ? stat_byte(usr_a_reg, cd_a_reg,
          ibf_a_reg, obf_a_reg) : odr_a_reg;
      else
        host_data_out <= s2_reg.addr ? stat_byte(usr_b_reg, cd_b_reg,
          ibf_b_reg, obf_b_reg) : odr_b_reg;
    end
  end

  // pins toward host and slave interrupts
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_gate_pin <= 1'b1;
      addr_gate_oe <= 1'b0;
      host_req_a <= 1'b0;
      host_req_b <= 1'b0;
      host_req_c <= 1'b0;
      chan_a_input_irq <= 1'b0;
      chan_b_input_irq <= 1'b0;
    end
    else
    begin
      addr_gate_pin <= port_reg[`HSP_GATE_BIT];
      addr_gate_oe <= dir_reg[`HSP_GATE_BIT];
      host_req_b <= h_en && hreq_reg[0];
      host_req_a <= h_en && hreq_reg[1];
      host_req_c <= h_en && hreq_reg[2];
      chan_a_input_irq <= hpc_reg[`HSP_IEA_BIT] && ibf_a_reg;
      chan_b_input_irq <= hpc_reg[`HSP_IEB_BIT] && ibf_b_reg;
    end
  end

endmodule // hsp_top

// ---- hdl/hsp_map.svh ----
// register offsets, field positions, reset values and command codes
// assumes a 16-bit slave address taken from the low bits of haddr
`ifndef HSP_MAP_SVH
`define HSP_MAP_SVH
`define HSP_OFF_SYSCTL 16'hFFC4
`define HSP_OFF_HPCTL 16'hFFF0
`define HSP_OFF_A_IN 16'hFFF4
`define HSP_OFF_A_OUT 16'hFFF8
`define HSP_OFF_A_STAT 16'hFFFC
`define HSP_OFF_B_IN 16'hFFE4
`define HSP_OFF_B_OUT 16'hFFE8
`define HSP_OFF_B_STAT 16'hFFEC
`define HSP_OFF_PORT 16'hFFB8
`define HSP_OFF_DIR 16'hFFBC
`define HSP_GUARD_HI 12'hFFF
`define HSP_SYSCTL_RST 8'h09
`define HSP_SYSCTL_RO 8'h08
`define HSP_HPCTL_FILL 5'h1F
`define HSP_PORT_RST 8'h80
`define HSP_HIE_BIT 1
`define HSP_FGE_BIT 0
`define HSP_IEA_BIT 1
`define HSP_IEB_BIT 2
`define HSP_GATE_BIT 7
`define HSP_STAT_USER 8'hF4
`define HSP_CMD_GATE 8'hD1
`define HSP_CMD_END 8'hFF
`define HSP_HOST_IDLE 13'h1E00
`define HSP_HSIZE_WORD 3'h2
`endif

// ---- hdl/hsp_pkg.sv ----
// types shared by the host slave port
// assumes nothing beyond the map header
package hsp_pkg;
  // host pins as sampled, all active low except addr and data
  typedef struct packed {
    logic a_sel_n;
    logic b_sel_n;
    logic rd_n;
    logic wr_n;
    logic addr;
    logic [7:0] data;
  } hsp_host_in_t;
  // fast gate decoder states
  typedef enum logic [2:0] {
    GS_IDLE = 3'b001,
    GS_WAIT = 3'b010,
    GS_DONE = 3'b100
  } hsp_gate_state_t;
  // slave register selected by an address
  typedef enum logic [3:0] {
    SEL_NONE, SEL_SYS, SEL_HPC, SEL_A_IN, SEL_A_OUT, SEL_A_STAT,
    SEL_B_IN, SEL_B_OUT, SEL_B_STAT, SEL_PORT, SEL_DIR
  } hsp_sel_t;
endpackage

// ---- dv/hsp_host_model.sv ----
// host processor model driving the host pins of the slave port
// assumes hclk from the bench and the device read outputs wired back
`timescale 1ns/1ns
module hsp_host_model
  import hsp_pkg::*;
(
  input wire logic hclk,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  output hsp_host_in_t host_in
);
  // idle pins at time zero
  initial host_in = 13'h1E00;

  // one strobe pulse, one access at a time, setup and hold of 4
  task automatic xfer(input logic b, input logic w, input logic a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge hclk);
    host_in.a_sel_n <= b;
    host_in.b_sel_n <= !b;
    host_in.addr <= a;
    host_in.data <= d;
    repeat (4) @(posedge hclk);
    if (w)
      host_in.wr_n <= 1'b0;
    else
      host_in.rd_n <= 1'b0;
    repeat (5) @(posedge hclk);
    q = host_data_oe ? host_data_out : 8'hXX;
    host_in.wr_n <= 1'b1;
    host_in.rd_n <= 1'b1;
    repeat (4) @(posedge hclk);
    // released bus shows the inverse of the last byte
    host_in.a_sel_n <= 1'b1;
    host_in.b_sel_n <= 1'b1;
    host_in.data <= ~d;
    repeat (5) @(posedge hclk);
  endtask
endmodule // hsp_host_model

// ---- dv/hsp_checker.sv ----
// port-level assertions for the host slave port
// assumes binding to hsp_top with hready fed from hreadyout
`timescale 1ns/1ns
module hsp_checker
  import hsp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire hsp_host_in_t host_in,
  input wire logic host_data_oe,
  input wire logic addr_gate_pin,
  input wire logic host_req_a,
  input wire logic host_req_b,
  input wire logic host_req_c,
  input wire logic chan_a_input_irq,
  input wire logic chan_b_input_irq
);
  logic acc;
  logic [3:0] quiet;
  logic [3:0] slv;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // accepted bus transfer
  assign acc = hsel && htrans[1] && hready && hsize == 3'h2;

  // cycles since a host write strobe or a slave write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      quiet <= 4'h0;
    else if (!host_in.wr_n || (acc && hwrite))
      quiet <= 4'h0;
    else if (quiet != 4'hF)
      quiet <= quiet + 4'h1;
  end

  // cycles since a slave write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      slv <= 4'h0;
    else if (acc && hwrite)
      slv <= 4'h0;
    else if (slv != 4'hF)
      slv <= slv + 4'h1;
  end

  sequence wr_acc;
    acc && hwrite;
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  resp_okay_a: assert property (hresp == 1'b0)
    else $error("slave response not okay");
  write_wait_a: assert property (wr_acc |=> one_wait)
    else $error("write wait state wrong");
  read_nowait_a: assert property (acc && !hwrite |=> hreadyout)
    else $error("read stalled");
  rdata_hold_a: assert property (!(acc && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  drive_on_read_a: assert property (host_data_oe |->
    !$past(host_in.rd_n, 2) || !$past(host_in.rd_n, 3) ||
    !$past(host_in.rd_n, 4) || !$past(host_in.rd_n, 5))
    else $error("host bus driven without read");
  gate_cause_a: assert property ($changed(addr_gate_pin) |->
    quiet < 4'h8)
    else $error("gate pin moved without a write");
  req_cause_a: assert property ($rose(host_req_a) ||
    $rose(host_req_b) || $rose(host_req_c) |-> slv < 4'h6)
    else $error("host request set without slave write");
  irq_cause_a: assert property ($rose(chan_a_input_irq) ||
    $rose(chan_b_input_irq) |-> quiet < 4'h8)
    else $error("input irq rose without a write");
endmodule // hsp_checker

bind hsp_top hsp_checker u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hsize, .hready, .hrdata, .hreadyout, .hresp, .host_in, .host_data_oe,
  .addr_gate_pin, .host_req_a, .host_req_b, .host_req_c,
  .chan_a_input_irq, .chan_b_input_irq);

// ---- dv/hsp_top_bench.sv ----
// self-checking bench for the host slave port
// assumes the host model and checker are compiled before this file
`timescale 1ns/1ns
`include "hsp_map.svh"
module hsp_top_bench
  import hsp_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] host_data_out;
  logic host_data_oe, pin, pin_oe, req_a, req_b, req_c, irq_a, irq_b;
  hsp_host_in_t host_in;
  int err_total, num_checks;

  // 250 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  hsp_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .host_in(host_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .addr_gate_pin(pin), .addr_gate_oe(pin_oe), .host_req_a(req_a),
    .host_req_b(req_b), .host_req_c(req_c), .chan_a_input_irq(irq_a),
    .chan_b_input_irq(irq_b));

  hsp_host_model host (.hclk(hclk), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .host_in(host_in));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // wait for hready under a bound
  task automatic rdy(inout int n);
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
  endtask

  // one single word transfer
  task automatic ahb(input logic w, input logic [15:0] a,
    input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {16'h0000, a};
    rdy(n);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    rdy(n);
    r = hrdata;
    if (n >= 50)
    begin
      err_total++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 8'h00, r);
    chk(r, {24'h000000, e});
  endtask

  task automatic hw(input logic b, input logic a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(b, 1'b1, a, d, q);
  endtask

  task automatic hr(input logic b, input logic a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer(b, 1'b0, a, 8'h00, q);
    chk({24'h000000, q}, {24'h000000, e});
  endtask

  task automatic t_reset();
    rdc(`HSP_OFF_SYSCTL, 8'h09);
    rdc(`HSP_OFF_HPCTL, 8'h00);
    rdc(16'h1000, 8'h00);
    hw(1'b0, 1'b0, 8'h11);
    wr(`HSP_OFF_SYSCTL, 8'h03);
    rdc(`HSP_OFF_SYSCTL, 8'h0B);
    rdc(`HSP_OFF_HPCTL, 8'hF8);
    rdc(`HSP_OFF_A_STAT, 8'h00);
    rdc(`HSP_OFF_PORT, 8'h80);
    $display("reset test done");
  endtask

  task automatic t_chan_b();
    hw(1'b1, 1'b1, 8'h33);
    rdc(`HSP_OFF_B_STAT, 8'h0A);
    rdc(`HSP_OFF_B_IN, 8'h33);
    rdc(`HSP_OFF_B_STAT, 8'h08);
    hw(1'b1, 1'b0, 8'h44);
    rdc(`HSP_OFF_B_STAT, 8'h02);
    rdc(`HSP_OFF_B_IN, 8'h44);
    $display("channel b test done");
  endtask

  task automatic t_out();
    wr(`HSP_OFF_B_OUT, 8'h5A);
    rdc(`HSP_OFF_B_STAT, 8'h01);
    hr(1'b1, 1'b1, 8'h01);
    hr(1'b1, 1'b0, 8'h5A);
    rdc(`HSP_OFF_B_STAT, 8'h00);
    wr(`HSP_OFF_A_OUT, 8'hA5);
    hr(1'b0, 1'b1, 8'h01);
    hr(1'b0, 1'b0, 8'hA5);
    $display("output test done");
  endtask

  task automatic t_irq();
    wr(`HSP_OFF_HPCTL, 8'h06);
    hw(1'b0, 1'b0, 8'h21);
    hw(1'b1, 1'b0, 8'h22);
    chk({30'h0, irq_b, irq_a}, 32'h3);
    rdc(`HSP_OFF_A_IN, 8'h21);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq_a}, 32'h0);
    wr(`HSP_OFF_HPCTL, 8'h00);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq_b}, 32'h0);
    rdc(`HSP_OFF_B_IN, 8'h22);
    $display("irq test done");
  endtask

  task automatic t_req();
    rdc(`HSP_OFF_PORT, 8'h80);
    wr(`HSP_OFF_PORT, 8'hB8);
    repeat (3) @(posedge hclk);
    chk({29'h0, req_c, req_b, req_a}, 32'h7);
    hr(1'b1, 1'b0, 8'h5A);
    chk({29'h0, req_c, req_b, req_a}, 32'h5);
    hr(1'b0, 1'b0, 8'hA5);
    chk({29'h0, req_c, req_b, req_a}, 32'h0);
    wr(`HSP_OFF_PORT, 8'h88);
    repeat (3) @(posedge hclk);
    chk({31'h0, req_b}, 32'h0);
    rdc(`HSP_OFF_PORT, 8'h80);
    wr(`HSP_OFF_PORT, 8'h88);
    repeat (3) @(posedge hclk);
    chk({31'h0, req_b}, 32'h1);
    wr(`HSP_OFF_PORT, 8'h80);
    repeat (3) @(posedge hclk);
    chk({31'h0, req_b}, 32'h0);
    $display("request test done");
  endtask

  task automatic t_gate();
    wr(`HSP_OFF_DIR, 8'h80);
    wr(`HSP_OFF_HPCTL, 8'h01);
    chk({30'h0, pin_oe, pin}, 32'h3);
    hw(1'b0, 1'b1, `HSP_CMD_GATE);
    hw(1'b0, 1'b0, 8'hFD);
    chk({31'h0, pin}, 32'h0);
    hw(1'b0, 1'b1, `HSP_CMD_END);
    rdc(`HSP_OFF_A_STAT, 8'h08);
    hw(1'b0, 1'b1, `HSP_CMD_GATE);
    hw(1'b0, 1'b1, `HSP_CMD_GATE);
    rdc(`HSP_OFF_A_STAT, 8'h08);
    hw(1'b0, 1'b0, 8'h02);
    chk({31'h0, pin}, 32'h1);
    hw(1'b1, 1'b1, `HSP_CMD_GATE);
    hw(1'b1, 1'b0, 8'h00);
    chk({31'h0, pin}, 32'h1);
    wr(`HSP_OFF_PORT, 8'h00);
    repeat (2) @(posedge hclk);
    chk({31'h0, pin}, 32'h1);
    hw(1'b0, 1'b1, 8'h12);
    rdc(`HSP_OFF_A_STAT, 8'h0A);
    rdc(`HSP_OFF_A_IN, 8'h12);
    hw(1'b0, 1'b1, `HSP_CMD_GATE);
    hw(1'b0, 1'b1, 8'h12);
    rdc(`HSP_OFF_A_STAT, 8'h0A);
    chk({31'h0, pin}, 32'h1);
    wr(`HSP_OFF_HPCTL, 8'h00);
    wr(`HSP_OFF_PORT, 8'h00);
    repeat (2) @(posedge hclk);
    chk({31'h0, pin}, 32'h0);
    $display("gate test done");
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `HSP_HSIZE_WORD;
    hwdata = 32'h00000000;
    err_total = 0;
    num_checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_chan_b();
    t_out();
    t_irq();
    t_req();
    t_gate();
    end_of_test();
  end
endmodule // hsp_top_bench
